/* hdl/acss_scan.sv */
// adc channel scan select: selection registers and scan sequencer
//
// Function
// - convert only inputs whose select bit set
// - visit low register bits 14 down to 0
// - then high register bits 14 to 12
// - single-ended results unsigned to own register
// - pair A: in0 minus in1, to reg 0
// - pair B: in2 minus in3, to reg 2
// - any in0/in1 single bit ignores pair A
// - pair A only when 14,13 clear, 12 set
// - any in2/in3 single bit ignores pair B
// - pair B only when 11,10 clear, 9 set
// - all three clear skips whole group
// - low bits 8..0 select inputs 4..12
// - high bits 14..12 select inputs 13..15
// - both registers reset to zero
`timescale 1ns/100ps
`default_nettype none

module acss_scan
  import acss_pkg::*;
(
  input  wire logic               CLK,        // 50 MHz logic clock
  input  wire logic               SRST,       // sync reset, active high
  input  wire acss_pkg::acss_reg_req_type REG_REQ, // register access
  output logic [15:0]             REG_RDATA,  // read data, registered
  output logic                    REG_RVALID, // read data valid pulse
  input  wire logic               SCAN_START, // start one scan pass
  output logic                    SCAN_BUSY,  // scan in progress
  output logic                    CONV_VALID, // conversion request
  input  wire logic               CONV_READY, // converter takes request
  input  wire logic               CONV_DONE,  // converter finished
  output acss_pkg::acss_conv_type CONV_REQ,   // request contents
  output logic [15:0]             SEL_LOW,    // scan_select_low value
  output logic [15:0]             SEL_HIGH    // scan_select_high value
);
  import acss_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]    sel_low;   // scan_select_low
    logic [15:0]    sel_high;  // scan_select_high
    logic [15:0]    rdata;     // read data
    logic           rvalid;    // read strobe
    acss_state_type st;        // sequencer state
    logic [4:0]     slot;      // current scan slot
  } acss_regs_type;

  acss_regs_type r_q;  // registered state
  acss_regs_type r_d;  // next state

  // per-slot enable and request decode
  logic [SLOT_COUNT-1:0] slot_en;                 // slot will be converted
  acss_conv_type         slot_conv [SLOT_COUNT];  // request for each slot
  logic                  grp_a_single;            // in0 or in1 single
  logic                  grp_b_single;            // in2 or in3 single

  // ----------------------------------------------------------------------
  // slot decode: slot k is low bit (14-k), slots 15..17 are high 14..12
  // ----------------------------------------------------------------------
  assign grp_a_single = r_q.sel_low[SEL_IN0_BIT] | r_q.sel_low[SEL_IN1_BIT];
  assign grp_b_single = r_q.sel_low[SEL_IN2_BIT] | r_q.sel_low[SEL_IN3_BIT];

  genvar k;
  generate
    for (k = 0; k < SLOT_COUNT; k++) begin : g_slot
      if (k < 15) begin : g_low
        localparam int B = 14 - k;  // bit in the low register
        if (B == DIFF_A_BIT) begin : g_da
          // pair disregarded whenever a single bit of the group is set
          assign slot_en[k] = r_q.sel_low[B] & ~grp_a_single;
          assign slot_conv[k] = '{input_num: 4'h0, diff: 1'b1};
        end else if (B == DIFF_B_BIT) begin : g_db
          assign slot_en[k] = r_q.sel_low[B] & ~grp_b_single;
          assign slot_conv[k] = '{input_num: 4'h2, diff: 1'b1};
        end else begin : g_se
          // inputs 0,1 at 14,13; 2,3 at 11,10; 4..12 at 8..0
          localparam int N = (B > DIFF_A_BIT) ? (14 - B) :
                             (B > DIFF_B_BIT) ? (13 - B) : (12 - B);
          assign slot_en[k] = r_q.sel_low[B];
          assign slot_conv[k] = '{input_num: 4'(N), diff: 1'b0};
        end
      end else begin : g_high
        localparam int B = SEL_HIGH_TOP - (k - 15);
        assign slot_en[k] = r_q.sel_high[B];
        assign slot_conv[k] = '{input_num: 4'(13 + k - 15), diff: 1'b0};
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic       found;
    logic [4:0] nxt;
    found = 1'b0;
    nxt   = 5'h00;
    r_d   = r_q;
    r_d.rvalid = 1'b0;
    // register writes; bit 15 of low is read-only zero
    if (REG_REQ.wr) begin
      if (REG_REQ.addr == ADDR_SCAN_LOW)
        r_d.sel_low = REG_REQ.wdata & MASK_SCAN_LOW;
      else if (REG_REQ.addr == ADDR_SCAN_HIGH)
        r_d.sel_high = REG_REQ.wdata;
    end
    // register reads; unmapped addresses return zero
    if (REG_REQ.rd) begin
      r_d.rvalid = 1'b1;
      case (REG_REQ.addr)
        ADDR_SCAN_LOW:  r_d.rdata = r_q.sel_low;
        ADDR_SCAN_HIGH: r_d.rdata = r_q.sel_high;
        default:        r_d.rdata = 16'h0000;
      endcase
    end
    // search for first enabled slot at or after r_q.slot, descending bits
    for (int i = SLOT_COUNT - 1; i >= 0; i--) begin
      if (slot_en[i] && (5'(i) >= r_q.slot)) begin
        found = 1'b1;
        nxt   = 5'(i);
      end
    end
    case (r_q.st)
      ACSS_IDLE: begin
        if (SCAN_START) begin
          r_d.slot = 5'h00;
          r_d.st   = ACSS_REQ;
        end
      end
      ACSS_REQ: begin
        if (!found) begin
          r_d.st = ACSS_IDLE;   // pass complete, nothing left
        end else begin
          r_d.slot = nxt;
          if (CONV_VALID && CONV_READY)
            r_d.st = ACSS_WAIT;
        end
      end
      ACSS_WAIT: begin
        if (CONV_DONE) begin
          r_d.slot = r_q.slot + 5'h01; // go on with following bit
          r_d.st   = ACSS_REQ;
        end
      end
      default: r_d.st = ACSS_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // register the whole state
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      r_q          <= '0;
      r_q.sel_low  <= RESET_SCAN_LOW;
      r_q.sel_high <= RESET_SCAN_HIGH;
      r_q.st       <= ACSS_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs; request is offered combinationally from the search result
  // ----------------------------------------------------------------------
  logic       req_found;  // an enabled slot remains
  logic [4:0] req_slot;   // that slot
  always_comb begin
    req_found = 1'b0;
    req_slot  = 5'h00;
    for (int i = SLOT_COUNT - 1; i >= 0; i--) begin
      if (slot_en[i] && (5'(i) >= r_q.slot)) begin
        req_found = 1'b1;
        req_slot  = 5'(i);
      end
    end
  end

  assign CONV_VALID = (r_q.st == ACSS_REQ) && req_found;
  assign CONV_REQ   = slot_conv[req_slot];
  assign SCAN_BUSY  = (r_q.st != ACSS_IDLE);
  assign REG_RDATA  = r_q.rdata;
  assign REG_RVALID = r_q.rvalid;
  assign SEL_LOW    = r_q.sel_low;
  assign SEL_HIGH   = r_q.sel_high;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  // the handshake checks share these three steps
  sequence s_take;
    CONV_VALID && CONV_READY;           // converter takes the offer
  endsequence

  sequence s_done;
    (r_q.st == ACSS_WAIT) && CONV_DONE; // converter reports back
  endsequence

  sequence s_start;
    SCAN_START && !SCAN_BUSY;           // a pass launched from idle
  endsequence

  // reset leaves both selection registers empty one edge later;
  // looked at only after a reset edge, so power-up unknowns before
  // the first reset edge never reach the check
  property p_reset_zero;
    @(posedge CLK)
      SRST |=> (SEL_LOW == RESET_SCAN_LOW &&
                SEL_HIGH == RESET_SCAN_HIGH);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("select not zero after reset");

  // the reserved top bit of the low register never holds a one
  property p_top_zero;
    @(posedge CLK) disable iff (SRST)
      SEL_LOW[15] == 1'b0;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("low bit 15 set");

  // pair A is only offered with both of its single bits clear
  property p_pair_a_block;
    @(posedge CLK) disable iff (SRST)
      (CONV_VALID && CONV_REQ.diff && CONV_REQ.input_num == 4'h0)
      |-> (!SEL_LOW[SEL_IN0_BIT] && !SEL_LOW[SEL_IN1_BIT] &&
           SEL_LOW[DIFF_A_BIT]);
  endproperty
  a_pair_a_block: assert property (p_pair_a_block)
    else $error("pair A wrong");

  // pair B likewise needs both of its single bits clear
  property p_pair_b_block;
    @(posedge CLK) disable iff (SRST)
      (CONV_VALID && CONV_REQ.diff && CONV_REQ.input_num == 4'h2)
      |-> (!SEL_LOW[SEL_IN2_BIT] && !SEL_LOW[SEL_IN3_BIT] &&
           SEL_LOW[DIFF_B_BIT]);
  endproperty
  a_pair_b_block: assert property (p_pair_b_block)
    else $error("pair B wrong");

  // a single request for input 0 only with its own bit set;
  // the pair bit alone must never turn into a single request
  property p_single_in0;
    @(posedge CLK) disable iff (SRST)
      (CONV_VALID && !CONV_REQ.diff && CONV_REQ.input_num == 4'h0)
      |-> SEL_LOW[SEL_IN0_BIT];
  endproperty
  a_single_in0: assert property (p_single_in0)
    else $error("input 0 unselected");

  // same for input 3 in the second group
  property p_single_in3;
    @(posedge CLK) disable iff (SRST)
      (CONV_VALID && !CONV_REQ.diff && CONV_REQ.input_num == 4'h3)
      |-> SEL_LOW[SEL_IN3_BIT];
  endproperty
  a_single_in3: assert property (p_single_in3)
    else $error("input 3 unselected");

  // input 4 sits at bit 8 of the low register
  property p_single_selected;
    @(posedge CLK) disable iff (SRST)
      (CONV_VALID && !CONV_REQ.diff && CONV_REQ.input_num == 4'h4)
      |-> SEL_LOW[SEL_LOW_TOP];
  endproperty
  a_single_selected: assert property (p_single_selected)
    else $error("input 4 unselected");

  // input 15 sits at bit 12 of the high register
  property p_high_selected;
    @(posedge CLK) disable iff (SRST)
      (CONV_VALID && CONV_REQ.input_num == 4'hF)
      |-> SEL_HIGH[SEL_HIGH_TOP-2];
  endproperty
  a_high_selected: assert property (p_high_selected)
    else $error("input 15 unselected");

  // nothing selected means nothing is ever offered
  property p_empty_no_req;
    @(posedge CLK) disable iff (SRST)
      (SEL_LOW == 16'h0000 && SEL_HIGH[14:12] == 3'b000)
      |-> !CONV_VALID;
  endproperty
  a_empty_no_req: assert property (p_empty_no_req)
    else $error("request with nothing selected");

  // once taken, the offer is withdrawn while the pass goes on
  property p_order;
    @(posedge CLK) disable iff (SRST)
      s_take |=> (!CONV_VALID && SCAN_BUSY);
  endproperty
  a_order: assert property (p_order)
    else $error("offer kept after take");

  // after a result the next offer lies past the slot just done,
  // so no input is converted twice within one pass
  property p_descend;
    @(posedge CLK) disable iff (SRST)
      s_done ##1 CONV_VALID |-> (req_slot > $past(r_q.slot));
  endproperty
  a_descend: assert property (p_descend)
    else $error("scan went backwards");

  // a start from idle opens a pass at the first slot
  property p_start;
    @(posedge CLK) disable iff (SRST)
      s_start |=> (SCAN_BUSY && r_q.slot == 5'h00);
  endproperty
  a_start: assert property (p_start)
    else $error("pass not opened at first slot");

  // with nothing left to offer the pass closes on the next edge
  property p_busy_drop;
    @(posedge CLK) disable iff (SRST)
      (r_q.st == ACSS_REQ && !CONV_VALID) |=> !SCAN_BUSY;
  endproperty
  a_busy_drop: assert property (p_busy_drop)
    else $error("pass kept open with nothing left");

endmodule : acss_scan

`default_nettype wire

/* hdl/acss_pkg.sv */
// package for the adc channel scan select block
package acss_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [6:0]  ADDR_SCAN_LOW   = 7'h50; // scan_select_low
  localparam logic [6:0]  ADDR_SCAN_HIGH  = 7'h51; // scan_select_high
  localparam logic [15:0] RESET_SCAN_LOW  = 16'h0000;
  localparam logic [15:0] RESET_SCAN_HIGH = 16'h0000;
  localparam logic [15:0] MASK_SCAN_LOW   = 16'h7FFF; // bit 15 reads zero

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int SEL_IN0_BIT   = 14; // single input 0
  localparam int SEL_IN1_BIT   = 13; // single input 1
  localparam int DIFF_A_BIT    = 12; // diff_pair_a_select
  localparam int SEL_IN2_BIT   = 11; // single input 2
  localparam int SEL_IN3_BIT   = 10; // single input 3
  localparam int DIFF_B_BIT    = 9;  // diff_pair_b_select
  localparam int SEL_LOW_TOP   = 8;  // inputs 4..12 at bits 8..0
  localparam int SEL_HIGH_TOP  = 14; // inputs 13..15 at bits 14..12
  localparam int SLOT_COUNT    = 18; // 15 low slots + 3 high slots

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ACSS_IDLE, ACSS_REQ, ACSS_WAIT
  } acss_state_type;

  // one conversion request to the converter engine
  typedef struct packed {
    logic [3:0] input_num;   // positive input / result register index
    logic       diff;        // 1: differential, two's complement result
  } acss_conv_type;

  // register write/read port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } acss_reg_req_type;

endpackage : acss_pkg

/* test/acss_scan_tb.sv */
// self-checking bench for the channel scan select block
`timescale 1ns/100ps
`default_nettype none
module acss_scan_tb;
  import acss_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic             clk        = 1'b0; // 50 MHz logic clock
  logic             srst       = 1'b1; // held for 20 cycles at start
  acss_reg_req_type reg_req    = '0;   // register access pulses
  logic             scan_start = 1'b0;
  logic             conv_ready = 1'b0;
  logic             conv_done  = 1'b0;
  logic [15:0]      reg_rdata;
  logic             reg_rvalid;
  logic             scan_busy;
  logic             conv_valid;
  acss_conv_type    conv_req;
  logic [15:0]      sel_low;
  logic [15:0]      sel_high;
  int               fail_count = 0;
  int               cmp_count  = 0;
  acss_conv_type    exp_q[$];          // expected visiting order

  acss_scan u_acss_scan (
    .CLK(clk), .SRST(srst), .REG_REQ(reg_req), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .SCAN_START(scan_start),
    .SCAN_BUSY(scan_busy), .CONV_VALID(conv_valid),
    .CONV_READY(conv_ready), .CONV_DONE(conv_done), .CONV_REQ(conv_req),
    .SEL_LOW(sel_low), .SEL_HIGH(sel_high)
  );

  // free-running clock, 20 ns period
  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // compare and access tasks
  // ----------------------------------------------------------------
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_conv(input acss_conv_type got,
                          input acss_conv_type exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write: one-cycle wr pulse, visible from the next cycle
  task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk) reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) reg_req <= '0;
  endtask

  // read: data and valid pulse stand one cycle after rd is taken
  task automatic reg_rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge clk) reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge clk) reg_req <= '0;
    @(negedge clk);
    cmp16({15'h0, reg_rvalid}, 16'h0001);
    cmp16(reg_rdata, exp);
  endtask

  // expected order: low bits 14..0, then high bits 14..12
  task automatic build(input logic [15:0] lo, input logic [15:0] hi);
    exp_q.delete();
    for (int b = 14; b >= 0; b--) begin
      if (lo[b] && b == 12) begin
        // pair only when both single bits of its group are clear
        if (!lo[14] && !lo[13]) exp_q.push_back('{4'h0, 1'b1});
      end else if (lo[b] && b == 9) begin
        if (!lo[11] && !lo[10]) exp_q.push_back('{4'h2, 1'b1});
      end else if (lo[b]) begin
        exp_q.push_back('{4'((b > 12) ? 14 - b : (b > 9) ? 13 - b
                                          : 12 - b), 1'b0});
      end
    end
    for (int b = 14; b >= 12; b--) begin
      if (hi[b]) exp_q.push_back('{4'(27 - b), 1'b0});
    end
  endtask

  // one scan pass; converter waits two cycles before done
  task automatic scan(input logic [15:0] lo, input logic [15:0] hi);
    int n;
    reg_wr(ADDR_SCAN_LOW, lo);
    reg_wr(ADDR_SCAN_HIGH, hi);
    build(lo, hi);
    @(posedge clk) scan_start <= 1'b1;
    @(posedge clk) scan_start <= 1'b0;
    foreach (exp_q[i]) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (conv_valid !== 1'b1 && n < 40);
      cmp16({15'h0, conv_valid}, 16'h0001);
      cmp_conv(conv_req, exp_q[i]);
      @(posedge clk) conv_ready <= 1'b1;
      @(posedge clk) conv_ready <= 1'b0;
      repeat (2) @(posedge clk);
      conv_done <= 1'b1;
      @(posedge clk) conv_done <= 1'b0;
    end
    // nothing further may be offered once the list is done
    repeat (4) @(negedge clk);
    cmp16({15'h0, scan_busy}, 16'h0000);
    cmp16({15'h0, conv_valid}, 16'h0000);
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    reg_rd(ADDR_SCAN_LOW, RESET_SCAN_LOW);
    reg_rd(ADDR_SCAN_HIGH, RESET_SCAN_HIGH);
    reg_wr(ADDR_SCAN_LOW, 16'hFFFF);
    reg_rd(ADDR_SCAN_LOW, 16'h7FFF);
    cmp16(sel_low, 16'h7FFF);
    reg_wr(ADDR_SCAN_HIGH, 16'hFFFF);
    reg_rd(ADDR_SCAN_HIGH, 16'hFFFF);
    cmp16(sel_high, 16'hFFFF);
    reg_rd(7'h52, 16'h0000);                 // unmapped place reads zero
    scan(16'h7E00, 16'h0000);
    scan(16'h1200, 16'h0000);
    scan(16'h5001, 16'h0000);
    scan(16'h2400, 16'h0000);
    scan(16'h01FF, 16'h7000);
    scan(16'h0000, 16'h8FFF);
    scan(16'h4A55, 16'h5000);
    // second reset in mid-run clears both registers
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    reg_rd(ADDR_SCAN_LOW, 16'h0000);
    reg_rd(ADDR_SCAN_HIGH, 16'h0000);
    summarize();
  end

  // watchdog: the whole run needs well under 3000 cycles
  initial begin
    #200us;
    fail_count++;
    summarize();
  end
endmodule // acss_scan_tb
`default_nettype wire
